// file: logic/dvsr_defines.svh
/*
 * Offsets, field positions, reset values and step codes of the digital
 * volume and soft-mute ramp block.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef DVSR_DEFINES_SVH
`define DVSR_DEFINES_SVH

// ============================================================
// Register offsets
`define DVSR_ADDR_LEFT 8'h3d
`define DVSR_ADDR_RIGHT 8'h3e
`define DVSR_ADDR_RAMP 8'h3f

// ============================================================
// Reset values
`define DVSR_RESET_VOLUME 8'h30
`define DVSR_RESET_RAMP 8'h33

// ============================================================
// Field positions in the ramp configuration register
`define DVSR_FALL_RATE_HI 7
`define DVSR_FALL_RATE_LO 6
`define DVSR_FALL_STEP_HI 5
`define DVSR_FALL_STEP_LO 4
`define DVSR_RISE_RATE_HI 3
`define DVSR_RISE_RATE_LO 2
`define DVSR_RISE_STEP_HI 1
`define DVSR_RISE_STEP_LO 0

// ============================================================
// Codes and steps
`define DVSR_CODE_MUTE 8'hff
`define DVSR_RATE_INSTANT 2'h3
`define DVSR_LINK_LEFT 2'h1
`define DVSR_STEP_4DB 8'h08
`define DVSR_STEP_2DB 8'h04
`define DVSR_STEP_1DB 8'h02
`define DVSR_STEP_HALF_DB 8'h01

`endif

// file: logic/dvsr_pkg.sv
/*
 * Types and decode functions of the digital volume ramp block.
 * Assumes the defines header is on the include path.
 */
`include "dvsr_defines.svh"

package dvsr_pkg;

    typedef logic [7:0] dvsr_code_t;
    typedef logic [1:0] dvsr_field_t;

    typedef enum logic [1:0] {
        DVSR_IDLE = 2'b00,
        DVSR_FALL = 2'b01,
        DVSR_HELD = 2'b10,
        DVSR_RISE = 2'b11
    } dvsr_state_e;

    // Step size in half-dB code units.
    function automatic dvsr_code_t dvsr_step(input dvsr_field_t sel);
        dvsr_code_t s;
        case (sel)
            2'h0: s = `DVSR_STEP_4DB;
            2'h1: s = `DVSR_STEP_2DB;
            2'h2: s = `DVSR_STEP_1DB;
            default: s = `DVSR_STEP_HALF_DB;
        endcase
        return s;
    endfunction

    // Last sample count of an update interval (1, 2 or 4 samples).
    function automatic dvsr_field_t dvsr_last(input dvsr_field_t rate);
        dvsr_field_t l;
        case (rate)
            2'h0: l = 2'h0;
            2'h1: l = 2'h1;
            default: l = 2'h3;
        endcase
        return l;
    endfunction

endpackage

// file: logic/dvsr_regs.sv
/*
 * Register file of the volume block: left code, right code, ramp config.
 * Assumes the serial control port in front of it yields one-cycle writes
 * with an address and data already decoded to bytes.
 */
`timescale 1ns/100ps
`include "dvsr_defines.svh"

module dvsr_regs (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    output dvsr_pkg::dvsr_code_t reg_rdata,
    output dvsr_pkg::dvsr_code_t left_gain_code,
    output dvsr_pkg::dvsr_code_t right_gain_code,
    output dvsr_pkg::dvsr_code_t ramp_config
);
    import dvsr_pkg::*;

    // ============================================================
    // Storage
    // left code store
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            left_gain_code <= `DVSR_RESET_VOLUME;
        end else if (reg_write && reg_addr == `DVSR_ADDR_LEFT) begin
            left_gain_code <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            right_gain_code <= `DVSR_RESET_VOLUME;
        end else if (reg_write && reg_addr == `DVSR_ADDR_RIGHT) begin
            right_gain_code <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ramp_config <= `DVSR_RESET_RAMP;
        end else if (reg_write && reg_addr == `DVSR_ADDR_RAMP) begin
            ramp_config <= reg_wdata;
        end
    end

    // ============================================================
    // Readback
    // Unmapped addresses read as zero so the port never returns stale data.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_addr)
                `DVSR_ADDR_LEFT: reg_rdata <= left_gain_code;
                `DVSR_ADDR_RIGHT: reg_rdata <= right_gain_code;
                `DVSR_ADDR_RAMP: reg_rdata <= ramp_config;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule // dvsr_regs

// file: logic/dvsr_top.sv
/*
 * Digital volume with soft-mute ramp for a stereo path.
 * Assumes frame_tick pulses for one clock once per audio sample period,
 * and that the link select and mute control bit come from registers
 * kept elsewhere in the device.
 */
`timescale 1ns/100ps
`include "dvsr_defines.svh"

module dvsr_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic frame_tick,
    input wire logic soft_mute_pin_n,
    input wire logic soft_mute_bit,
    input wire logic [1:0] gain_link_select,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    output dvsr_pkg::dvsr_code_t reg_rdata,
    output dvsr_pkg::dvsr_code_t left_gain_out,
    output dvsr_pkg::dvsr_code_t right_gain_out,
    output logic left_muted,
    output logic right_muted,
    output logic ramp_active
);
    import dvsr_pkg::*;

    // ============================================================
    // Registers
    dvsr_code_t left_gain_code;
    dvsr_code_t right_gain_code;
    dvsr_code_t ramp_config;

    dvsr_regs u_regs (
        .clk(clk),
        .reset_n(reset_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .reg_rdata(reg_rdata),
        .left_gain_code(left_gain_code),
        .right_gain_code(right_gain_code),
        .ramp_config(ramp_config)
    );

    // ============================================================
    // Field split
    dvsr_field_t fall_update_rate;
    dvsr_field_t fall_step_size;
    dvsr_field_t rise_update_rate;
    dvsr_field_t rise_step_size;
    dvsr_code_t fall_step;
    dvsr_code_t rise_step;
    dvsr_field_t fall_last;
    dvsr_field_t rise_last;
    logic fall_instant;
    logic rise_instant;

    assign fall_update_rate =
        ramp_config[`DVSR_FALL_RATE_HI:`DVSR_FALL_RATE_LO];
    assign fall_step_size =
        ramp_config[`DVSR_FALL_STEP_HI:`DVSR_FALL_STEP_LO];
    assign rise_update_rate =
        ramp_config[`DVSR_RISE_RATE_HI:`DVSR_RISE_RATE_LO];
    assign rise_step_size =
        ramp_config[`DVSR_RISE_STEP_HI:`DVSR_RISE_STEP_LO];

    assign fall_step = dvsr_step(fall_step_size);
    assign rise_step = dvsr_step(rise_step_size);
    assign fall_last = dvsr_last(fall_update_rate);
    assign fall_instant = (fall_update_rate == `DVSR_RATE_INSTANT);
    assign rise_last = dvsr_last(rise_update_rate);
    assign rise_instant = (rise_update_rate == `DVSR_RATE_INSTANT);

    // ============================================================
    // Mute request and channel targets
    logic mute_req;
    dvsr_code_t target [2];

    assign mute_req = !soft_mute_pin_n || soft_mute_bit;

    // right follows left when the link select is 1
    // Reserved link codes fall back to independent channels.
    assign target[0] = left_gain_code;
    assign target[1] = (gain_link_select == `DVSR_LINK_LEFT) ?
        left_gain_code : right_gain_code;

    // ============================================================
    // Per-channel ramp
    dvsr_code_t chan_gain [2];
    dvsr_state_e chan_state [2];

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            dvsr_state_e state;
            dvsr_state_e next_state;
            dvsr_code_t gain;
            dvsr_code_t next_gain;
            dvsr_field_t icount;
            dvsr_field_t next_icount;
            logic [8:0] fall_sum;
            logic [8:0] rise_floor;

            // Nine bits keep the sums from wrapping past mute or +24 dB.
            assign fall_sum = {1'b0, gain} + {1'b0, fall_step};
            assign rise_floor = {1'b0, target[ch]} + {1'b0, rise_step};

            always_comb begin
                next_state = state;
                next_gain = gain;
                next_icount = icount;
                case (state)
                    DVSR_IDLE: begin
                        if (mute_req) begin
                            next_icount = 2'h0;
                            if (fall_instant) begin
                                next_gain = `DVSR_CODE_MUTE;
                                next_state = DVSR_HELD;
                            end else begin
                                next_state = DVSR_FALL;
                            end
                        end else if (frame_tick) begin
                            next_gain = target[ch];
                        end
                    end
                    DVSR_FALL: begin
                        if (!mute_req) begin
                            next_icount = 2'h0;
                            next_state = DVSR_RISE;
                        end else if (fall_instant) begin
                            next_gain = `DVSR_CODE_MUTE;
                            next_state = DVSR_HELD;
                        end else if (frame_tick) begin
                            if (icount >= fall_last) begin
                                next_icount = 2'h0;
                                if (fall_sum >= {1'b0, `DVSR_CODE_MUTE}) begin
                                    next_gain = `DVSR_CODE_MUTE;
                                    next_state = DVSR_HELD;
                                end else begin
                                    next_gain = fall_sum[7:0];
                                end
                            end else begin
                                next_icount = icount + 2'h1;
                            end
                        end
                    end
                    DVSR_HELD: begin
                        next_gain = `DVSR_CODE_MUTE;
                        if (!mute_req) begin
                            next_icount = 2'h0;
                            if (rise_instant) begin
                                next_gain = target[ch];
                                next_state = DVSR_IDLE;
                            end else begin
                                next_state = DVSR_RISE;
                            end
                        end
                    end
                    DVSR_RISE: begin
                        if (mute_req) begin
                            next_icount = 2'h0;
                            next_state = DVSR_FALL;
                        end else if (rise_instant) begin
                            next_gain = target[ch];
                            next_state = DVSR_IDLE;
                        end else if (frame_tick) begin
                            if (icount >= rise_last) begin
                                next_icount = 2'h0;
                                if ({1'b0, gain} <= rise_floor) begin
                                    next_gain = target[ch];
                                    next_state = DVSR_IDLE;
                                end else begin
                                    next_gain = gain - rise_step;
                                end
                            end else begin
                                next_icount = icount + 2'h1;
                            end
                        end
                    end
                    default: begin
                        next_state = DVSR_IDLE;
                        next_icount = 2'h0;
                    end
                endcase
            end

            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    state <= DVSR_IDLE;
                end else begin
                    state <= next_state;
                end
            end

            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    gain <= `DVSR_RESET_VOLUME;
                end else begin
                    gain <= next_gain;
                end
            end

            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    icount <= 2'h0;
                end else begin
                    icount <= next_icount;
                end
            end

            assign chan_gain[ch] = gain;
            assign chan_state[ch] = state;
        end
    endgenerate

    // ============================================================
    // Outputs
    assign left_gain_out = chan_gain[0];
    assign right_gain_out = chan_gain[1];

    assign left_muted = (chan_gain[0] == `DVSR_CODE_MUTE);
    assign right_muted = (chan_gain[1] == `DVSR_CODE_MUTE);

    assign ramp_active = (chan_state[0] == DVSR_FALL) ||
        (chan_state[0] == DVSR_RISE) ||
        (chan_state[1] == DVSR_FALL) ||
        (chan_state[1] == DVSR_RISE);

endmodule // dvsr_top

// file: tb/dvsr_monitor.sv
/* Checker for the volume ramp block, watching only the top ports.
   Assumes it is bound to dvsr_top and runs on the block clock. */
`timescale 1ns/100ps
module dvsr_monitor (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic frame_tick,
    input wire logic soft_mute_pin_n,
    input wire logic soft_mute_bit,
    input wire logic [1:0] gain_link_select,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire dvsr_pkg::dvsr_code_t reg_rdata,
    input wire dvsr_pkg::dvsr_code_t left_gain_out,
    input wire dvsr_pkg::dvsr_code_t right_gain_out,
    input wire logic left_muted,
    input wire logic right_muted,
    input wire logic ramp_active
);
    import dvsr_pkg::*;
    logic [7:0] lreg, rreg, cfg, exp_rd, fstep, rstep, fnext, rnext;
    logic [8:0] fsum;
    logic mreq;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ====================
    // Shadow registers
    // Copies are kept from the write port, since no register is a port.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lreg <= 8'h30;
            rreg <= 8'h30;
            cfg <= 8'h33;
        end else if (reg_write) begin
            if (reg_addr == 8'h3d) lreg <= reg_wdata;
            if (reg_addr == 8'h3e) rreg <= reg_wdata;
            if (reg_addr == 8'h3f) cfg <= reg_wdata;
        end
    end
    assign mreq = !soft_mute_pin_n || soft_mute_bit;
    assign exp_rd = reg_addr == 8'h3d ? lreg : reg_addr == 8'h3e ? rreg
        : reg_addr == 8'h3f ? cfg : 8'h00;
    assign fstep = 8'h08 >> cfg[5:4];
    assign rstep = 8'h08 >> cfg[1:0];
    assign fsum = {1'b0, left_gain_out} + {1'b0, fstep};
    assign fnext = fsum >= 9'h0ff ? 8'hff : fsum[7:0];
    assign rnext = {1'b0, left_gain_out} <= {1'b0, lreg} + {1'b0, rstep}
        ? lreg : left_gain_out - rstep;
    // ====================
    // Assertions
    a_readback_data: assert property (
        !reg_write |=> reg_rdata == $past(exp_rd))
        else $error("read data wrong");
    a_fall_step_size: assert property (
        ramp_active && mreq && $past(mreq) && cfg[7:6] != 2'h3
        && !reg_write |=> $stable(left_gain_out)
        || left_gain_out == $past(fnext))
        else $error("fall step wrong");
    a_rise_step_size: assert property (
        ramp_active && !mreq && !$past(mreq) && cfg[3:2] != 2'h3
        && !reg_write |=> $stable(left_gain_out)
        || left_gain_out == $past(rnext))
        else $error("rise step wrong");
    a_gain_hold_between: assert property (
        ramp_active && !frame_tick && !reg_write && cfg[7:6] != 2'h3
        && cfg[3:2] != 2'h3 && mreq == $past(mreq)
        |=> $stable(left_gain_out) && $stable(right_gain_out))
        else $error("gain moved without tick");
    a_instant_mute: assert property (
        $rose(mreq) && cfg[7:6] == 2'h3 && !reg_write ##1 mreq
        |-> ##[0:1] left_muted && right_muted)
        else $error("instant mute late");
    a_instant_restore: assert property (
        $fell(mreq) && cfg[3:2] == 2'h3 && !reg_write ##1 !mreq
        |-> ##[0:1] left_gain_out == lreg)
        else $error("instant restore late");
    a_idle_target_load: assert property (
        frame_tick && !ramp_active && !mreq && !$past(mreq) && !reg_write
        |=> left_gain_out == lreg && right_gain_out ==
        ($past(gain_link_select) == 2'h1 ? lreg : rreg))
        else $error("target not loaded");
    a_mute_flag_match: assert property (
        left_muted == (left_gain_out == 8'hff)
        && right_muted == (right_gain_out == 8'hff)
        && (!($past(mreq) && $past(left_muted)) || left_muted))
        else $error("mute flag wrong");
endmodule // dvsr_monitor

// file: tb/testbench.sv
/* Self-checking bench for the volume ramp block: registers, target
   loading, soft mute ramps and instant modes.
   Assumes the design files and the checker are compiled first. */
`timescale 1ns/100ps
module testbench;
    import dvsr_pkg::*;
    logic clk, reset_n, frame_tick, soft_mute_pin_n, soft_mute_bit;
    logic reg_write, left_muted, right_muted, ramp_active;
    logic [1:0] gain_link_select;
    logic [7:0] reg_addr, reg_wdata, flags, st;
    dvsr_code_t reg_rdata, left_gain_out, right_gain_out;
    int fails, num_checks, s;
    assign flags = {5'h00, left_muted, right_muted, ramp_active};
    dvsr_top uut (.clk, .reset_n, .frame_tick, .soft_mute_pin_n,
        .soft_mute_bit, .gain_link_select, .reg_addr, .reg_wdata,
        .reg_write, .reg_rdata, .left_gain_out, .right_gain_out,
        .left_muted, .right_muted, .ramp_active);
    // ====================
    // Tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk);
        reg_write = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        @(negedge clk);
        chk(reg_rdata, exp);
    endtask
    // A sample period is three clocks, so ticks are never back to back.
    task automatic tk(input int n);
        repeat (n) begin
            frame_tick = 1'b1;
            @(negedge clk);
            frame_tick = 1'b0;
            repeat (2) @(negedge clk);
        end
    endtask
    task automatic mute(input logic m);
        soft_mute_pin_n = !m;
        @(negedge clk);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ====================
    // Stimulus
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #100000;
        fails++;
        complete_run();
    end
    initial begin
        fails = 0;
        num_checks = 0;
        {reset_n, frame_tick, soft_mute_bit, reg_write} = 4'h0;
        soft_mute_pin_n = 1'b1;
        gain_link_select = 2'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        repeat (5) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        rd(8'h3d, 8'h30);
        rd(8'h3e, 8'h30);
        rd(8'h3f, 8'h33);
        rd(8'h40, 8'h00);
        chk(left_gain_out, 8'h30);
        wr(8'h3d, 8'h00);
        wr(8'h3e, 8'hff);
        rd(8'h3e, 8'hff);
        tk(1);
        chk(left_gain_out, 8'h00);
        chk(flags, 8'h02);
        gain_link_select = 2'h1;
        tk(1);
        chk(right_gain_out, 8'h00);
        gain_link_select = 2'h0;
        tk(1);
        chk(right_gain_out, 8'hff);
        wr(8'h3d, 8'hd0);
        wr(8'h3e, 8'hd0);
        // Every step code is used both ways, reversing in mid-ramp.
        for (s = 0; s < 4; s++) begin
            st = 8'h08 >> s;
            wr(8'h3f, {2'h0, s[1:0], 2'h0, s[1:0]});
            tk(1);
            mute(1'b1);
            tk(1);
            chk(left_gain_out, 8'hd0 + st);
            tk(1);
            chk(left_gain_out, 8'hd0 + st + st);
            chk(right_gain_out, 8'hd0 + st + st);
            mute(1'b0);
            tk(1);
            chk(left_gain_out, 8'hd0 + st);
            tk(1);
            chk(left_gain_out, 8'hd0);
            chk(flags, 8'h00);
        end
        wr(8'h3d, 8'he0);
        wr(8'h3e, 8'he0);
        wr(8'h3f, 8'h49);
        tk(1);
        soft_mute_bit = 1'b1;
        @(negedge clk);
        tk(1);
        chk(left_gain_out, 8'he0);
        chk(flags, 8'h01);
        tk(1);
        chk(left_gain_out, 8'he8);
        tk(6);
        chk(flags, 8'h06);
        soft_mute_bit = 1'b0;
        @(negedge clk);
        tk(3);
        chk(left_gain_out, 8'hff);
        tk(1);
        chk(left_gain_out, 8'hfb);
        tk(28);
        chk(left_gain_out, 8'he0);
        chk(flags, 8'h00);
        wr(8'h3f, 8'hcc);
        rd(8'h3f, 8'hcc);
        mute(1'b1);
        @(negedge clk);
        chk(flags, 8'h06);
        mute(1'b0);
        @(negedge clk);
        chk(right_gain_out, 8'he0);
        reset_n = 1'b0;
        @(negedge clk);
        chk(left_gain_out, 8'h30);
        chk(right_gain_out, 8'h30);
        reset_n = 1'b1;
        rd(8'h3f, 8'h33);
        complete_run();
    end
endmodule // testbench

bind dvsr_top dvsr_monitor mon (.clk, .reset_n, .frame_tick,
    .soft_mute_pin_n, .soft_mute_bit, .gain_link_select, .reg_addr,
    .reg_wdata, .reg_write, .reg_rdata, .left_gain_out, .right_gain_out,
    .left_muted, .right_muted, .ramp_active);
